/* File: hdl/cell_channel.sv */
// Functional notes
// - The cell size field is bits 15-0; a value N moves N bytes per trigger and zero moves 65,536.
// - Bits 31-16 of the cell size and cell progress registers read zero and ignore writes.
// - Cell progress is a read-only 16-bit count of bytes moved since the trigger that armed the cell, cleared when the cell ends and zero at reset.
// - In pattern detect mode a byte equal to the match byte clears the progress count.
// - In pattern terminate mode a matching byte ends the transfer; plain mode and the unused mode value 3 ignore the match byte.
// - Bits 31-8 of the match register read zero and the match byte resets to zero.
`timescale 1ns/1ps
module cell_channel
	import cell_pkg::*;
#(
	parameter int unsigned DEPTH = cell_pkg::FIFO_DEPTH
) (
	input  wire logic                        core_clk,
	input  wire logic                        reset,
	input  wire cell_pkg::reg_req_t          reg_req,
	output logic [cell_pkg::REG_W-1:0]       rd_data,
	input  wire logic                        trigger_event,
	input  wire cell_pkg::byte_beat_t        src_beat,
	output logic                             src_ready,
	output cell_pkg::byte_beat_t             dst_beat,
	input  wire logic                        dst_ready,
	output logic                             cell_done,
	output logic                             match_end
);
	import cell_pkg::*;

	if (DEPTH < 4) begin : g_depth_check
		$error("cell_channel needs a buffer depth of at least 4");
	end

	localparam int unsigned LW = $clog2(DEPTH) + 1;

	// Register state
	logic                enable_q, enable_d;
	match_mode_t         mode_q, mode_d;
	logic [SIZE_W-1:0]   cell_byte_count_q, cell_byte_count_d;
	logic [MATCH_W-1:0]  match_byte_q, match_byte_d;
	logic                done_flag_q, done_flag_d;
	logic                hit_flag_q, hit_flag_d;
	logic [REG_W-1:0]    rd_data_q, rd_data_d;

	// Transfer state
	chan_state_t         state_q, state_d;
	logic [SIZE_W-1:0]   cell_progress_count_q, cell_progress_count_d;
	logic                src_ready_q, src_ready_d;
	logic                cell_done_q, cell_done_d;
	logic                match_end_q, match_end_d;

	logic                accept;
	logic                is_match;
	logic [SIZE_W:0]     target;
	logic [SIZE_W:0]     progress_next;
	logic                cell_end;
	logic                detect_clear;
	logic                term_end;
	logic                fifo_in_ready;
	logic                fifo_out_valid;
	logic [BYTE_W-1:0]   fifo_out_data;
	logic [LW-1:0]       fifo_level;
	logic [REG_W-1:0]    wd;

	assign rd_data        = rd_data_q;
	assign src_ready      = src_ready_q;
	assign cell_done      = cell_done_q;
	assign match_end      = match_end_q;
	assign dst_beat.valid = fifo_out_valid;
	assign dst_beat.data  = fifo_out_data;
	assign wd             = reg_req.wdata;

	// Bytes queue here so a slow destination stalls the source
	cell_fifo #(
		.WIDTH (BYTE_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.reset     (reset),
		.in_valid  (accept),
		.in_data   (src_beat.data),
		.in_ready  (fifo_in_ready),
		.out_valid (fifo_out_valid),
		.out_data  (fifo_out_data),
		.out_ready (dst_ready),
		.level     (fifo_level)
	);

	// Datapath decode
	always_comb begin
		accept        = src_beat.valid && src_ready_q && fifo_in_ready;
		is_match      = (src_beat.data == match_byte_q);
		target        = (cell_byte_count_q == '0) ? CELL_FULL_SIZE
			: {1'b0, cell_byte_count_q};
		progress_next = {1'b0, cell_progress_count_q} + 17'h00001;
		detect_clear  = accept && is_match && (mode_q == MODE_DETECT);
		term_end      = accept && is_match && (mode_q == MODE_TERMINATE);
		cell_end      = accept && (progress_next == target);
	end

	// Channel sequencing and progress count
	always_comb begin
		state_d               = state_q;
		cell_progress_count_d = cell_progress_count_q;
		cell_done_d           = 1'b0;
		match_end_d           = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (trigger_event && enable_q) begin
					state_d               = ST_ARMED;
					cell_progress_count_d = '0;
				end
			end
			ST_ARMED: begin
				if (!enable_q) begin
					state_d = ST_IDLE;
				end else if (term_end) begin
					state_d               = ST_IDLE;
					cell_progress_count_d = '0;
					match_end_d           = 1'b1;
				end else if (cell_end) begin
					state_d               = ST_IDLE;
					cell_progress_count_d = '0;
					cell_done_d           = 1'b1;
				end else if (detect_clear) begin
					cell_progress_count_d = '0;
				end else if (accept) begin
					cell_progress_count_d = progress_next[SIZE_W-1:0];
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// Two bytes of headroom because ready is a registered look-ahead
		src_ready_d = (state_d == ST_ARMED)
			&& (fifo_level < LW'(DEPTH - 1));
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q               <= ST_IDLE;
			cell_progress_count_q <= CELL_PROG_RST;
			src_ready_q           <= 1'b0;
			cell_done_q           <= 1'b0;
			match_end_q           <= 1'b0;
		end else begin
			state_q               <= state_d;
			cell_progress_count_q <= cell_progress_count_d;
			src_ready_q           <= src_ready_d;
			cell_done_q           <= cell_done_d;
			match_end_q           <= match_end_d;
		end
	end

	// Register writes and reads
	always_comb begin
		enable_d          = enable_q;
		mode_d            = mode_q;
		cell_byte_count_d = cell_byte_count_q;
		match_byte_d      = match_byte_q;
		done_flag_d       = done_flag_q;
		hit_flag_d        = hit_flag_q;
		rd_data_d         = '0;
		if (reg_req.wr_en) begin
			case (reg_req.addr)
				OFS_CONTROL: begin
					enable_d = wd[CTL_ENABLE_BIT];
					mode_d   = match_mode_t'(wd[CTL_MODE_LSB +: CTL_MODE_W]);
				end
				OFS_STATUS: begin
					// Write one to clear
					if (wd[STS_DONE_BIT]) begin
						done_flag_d = 1'b0;
					end
					if (wd[STS_HIT_BIT]) begin
						hit_flag_d = 1'b0;
					end
				end
				OFS_CELL_SIZE: begin
					cell_byte_count_d = wd[SIZE_W-1:0];
				end
				OFS_MATCH: begin
					match_byte_d = wd[MATCH_W-1:0];
				end
				default: begin
				end
			endcase
		end
		// A new event beats a clear in the same cycle
		if (cell_done_d) begin
			done_flag_d = 1'b1;
		end
		if (match_end_d) begin
			hit_flag_d = 1'b1;
		end
		if (reg_req.rd_en) begin
			case (reg_req.addr)
				OFS_CONTROL: begin
					rd_data_d[CTL_ENABLE_BIT]               = enable_q;
					rd_data_d[CTL_MODE_LSB +: CTL_MODE_W]   = mode_q;
				end
				OFS_STATUS: begin
					rd_data_d[STS_ARMED_BIT] = (state_q == ST_ARMED);
					rd_data_d[STS_DONE_BIT]  = done_flag_q;
					rd_data_d[STS_HIT_BIT]   = hit_flag_q;
				end
				OFS_CELL_SIZE: begin
					rd_data_d[SIZE_W-1:0] = cell_byte_count_q;
				end
				OFS_CELL_PROG: begin
					rd_data_d[SIZE_W-1:0] = cell_progress_count_q;
				end
				OFS_MATCH: begin
					rd_data_d[MATCH_W-1:0] = match_byte_q;
				end
				default: begin
					rd_data_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			enable_q          <= 1'b0;
			mode_q            <= MODE_PLAIN;
			cell_byte_count_q <= CELL_SIZE_RST;
			match_byte_q      <= MATCH_RST;
			done_flag_q       <= 1'b0;
			hit_flag_q        <= 1'b0;
			rd_data_q         <= '0;
		end else begin
			enable_q          <= enable_d;
			mode_q            <= mode_d;
			cell_byte_count_q <= cell_byte_count_d;
			match_byte_q      <= match_byte_d;
			done_flag_q       <= done_flag_d;
			hit_flag_q        <= hit_flag_d;
			rd_data_q         <= rd_data_d;
		end
	end

	// Checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	property p_cell_end;
		accept && !term_end && (state_q == ST_ARMED) && enable_q
			&& (progress_next == target)
			|=> cell_done_q && (cell_progress_count_q == '0) && (state_q == ST_IDLE);
	endproperty
	a_cell_end: assert property (p_cell_end) else $error("cell did not end at size");

	property p_full_cell;
		(cell_byte_count_q == '0) && accept && (state_q == ST_ARMED) && enable_q
			&& !detect_clear && !term_end && (cell_progress_count_q == 16'hfffe)
			|=> !cell_done_q && (cell_progress_count_q == 16'hffff);
	endproperty
	a_full_cell: assert property (p_full_cell) else $error("zero size ended early");

	property p_size_read;
		reg_req.rd_en && (reg_req.addr == OFS_CELL_SIZE)
			|=> (rd_data_q[REG_W-1:SIZE_W] == '0)
			&& (rd_data_q[SIZE_W-1:0] == $past(cell_byte_count_q));
	endproperty
	a_size_read: assert property (p_size_read) else $error("size read wrong");

	property p_prog_read;
		reg_req.rd_en && (reg_req.addr == OFS_CELL_PROG)
			|=> (rd_data_q[REG_W-1:SIZE_W] == '0)
			&& (rd_data_q[SIZE_W-1:0] == $past(cell_progress_count_q));
	endproperty
	a_prog_read: assert property (p_prog_read) else $error("progress read wrong");

	property p_count_up;
		accept && (state_q == ST_ARMED) && enable_q && !cell_end
			&& !detect_clear && !term_end
			|=> cell_progress_count_q == $past(cell_progress_count_q) + 16'h0001;
	endproperty
	a_count_up: assert property (p_count_up) else $error("progress did not count");

	property p_detect_clear;
		detect_clear && (state_q == ST_ARMED) && enable_q && !cell_end
			|=> (cell_progress_count_q == '0) && (state_q == ST_ARMED);
	endproperty
	a_detect_clear: assert property (p_detect_clear) else $error("detect did not clear");

	property p_term;
		term_end && (state_q == ST_ARMED) && enable_q
			|=> match_end_q && !cell_done_q && !src_ready_q && hit_flag_q;
	endproperty
	a_term: assert property (p_term) else $error("terminate match ignored");

	property p_plain_ignore;
		accept && (mode_q == MODE_PLAIN) |=> !match_end_q;
	endproperty
	a_plain_ignore: assert property (p_plain_ignore) else $error("match acted in plain mode");

	property p_match_read;
		reg_req.rd_en && (reg_req.addr == OFS_MATCH)
			|=> (rd_data_q[REG_W-1:MATCH_W] == '0)
			&& (rd_data_q[MATCH_W-1:0] == $past(match_byte_q));
	endproperty
	a_match_read: assert property (p_match_read) else $error("match read wrong");

	property p_wait_trigger;
		cell_done_q && !$past(trigger_event)
			|-> !src_ready_q && (state_q == ST_IDLE) && (cell_progress_count_q == '0);
	endproperty
	a_wait_trigger: assert property (p_wait_trigger) else $error("moved past cell end");

	// A clear written in the same cycle must not hide the event
	property p_done_sticky;
		cell_done_q |-> done_flag_q;
	endproperty
	a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

	property p_hit_sticky;
		match_end_q |-> hit_flag_q;
	endproperty
	a_hit_sticky: assert property (p_hit_sticky) else $error("hit flag lost");

	property p_ready_armed;
		src_ready_q |-> (state_q == ST_ARMED);
	endproperty
	a_ready_armed: assert property (p_ready_armed) else $error("ready while idle");

	property p_armed_trigger;
		trigger_event && (state_q == ST_ARMED) && enable_q && !accept
			|=> cell_progress_count_q == $past(cell_progress_count_q);
	endproperty
	a_armed_trigger: assert property (p_armed_trigger) else $error("event restarted cell");

	property p_read_idle;
		!reg_req.rd_en |=> rd_data_q == '0;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data did not clear");

	c_cell_done: cover property (cell_done_q);
	c_detect: cover property (detect_clear ##1 (cell_progress_count_q == '0));
	c_term: cover property (match_end_q);
	c_full: cover property (!fifo_in_ready);
	c_full_size: cover property (cell_done_q && (cell_byte_count_q == '0));

endmodule // cell_channel

/* File: hdl/cell_pkg.sv */
package cell_pkg;

	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned REG_W    = 32;
	localparam int unsigned BYTE_W   = 8;
	localparam int unsigned SIZE_W   = 16;
	localparam int unsigned MATCH_W  = 8;
	localparam int unsigned FIFO_DEPTH = 32;

	// Register byte addresses, one aligned word each
	localparam logic [ADDR_W-1:0] OFS_CONTROL  = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_CELL_SIZE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CELL_PROG = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_MATCH    = 8'h10;

	// Control fields
	localparam int unsigned CTL_ENABLE_BIT = 0;
	localparam int unsigned CTL_MODE_LSB   = 1;
	localparam int unsigned CTL_MODE_W     = 2;

	// Status fields
	localparam int unsigned STS_ARMED_BIT = 0;
	localparam int unsigned STS_DONE_BIT  = 1;
	localparam int unsigned STS_HIT_BIT   = 2;

	// Reset values
	localparam logic [SIZE_W-1:0]  CELL_SIZE_RST = 16'h0000;
	localparam logic [SIZE_W-1:0]  CELL_PROG_RST = 16'h0000;
	localparam logic [MATCH_W-1:0] MATCH_RST     = 8'h00;

	// Zero in the size field stands for one more than the field can hold
	localparam logic [SIZE_W:0] CELL_FULL_SIZE = 17'h10000;

	typedef enum logic [CTL_MODE_W-1:0] {
		MODE_PLAIN,
		MODE_DETECT,
		MODE_TERMINATE
	} match_mode_t;

	typedef enum logic {
		ST_IDLE,
		ST_ARMED
	} chan_state_t;

	typedef struct packed {
		logic              wr_en;
		logic              rd_en;
		logic [ADDR_W-1:0] addr;
		logic [REG_W-1:0]  wdata;
	} reg_req_t;

	typedef struct packed {
		logic              valid;
		logic [BYTE_W-1:0] data;
	} byte_beat_t;

endpackage

/* File: hdl/cell_fifo.sv */
`timescale 1ns/1ps
module cell_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input  wire logic                     core_clk,
	input  wire logic                     reset,
	input  wire logic                     in_valid,
	input  wire logic [WIDTH-1:0]         in_data,
	output logic                          in_ready,
	output logic                          out_valid,
	output logic [WIDTH-1:0]              out_data,
	input  wire logic                     out_ready,
	output logic [$clog2(DEPTH):0]        level
);
	localparam int unsigned AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
		$error("cell_fifo depth must be a power of two of at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q, wr_ptr_d;
	logic [AW-1:0]    rd_ptr_q, rd_ptr_d;
	logic [AW:0]      count_q, count_d;
	logic             out_valid_q, out_valid_d;
	logic [WIDTH-1:0] out_data_q;
	logic             push;
	logic             load;

	assign in_ready  = (count_q < (AW+1)'(DEPTH));
	assign out_valid = out_valid_q;
	assign out_data  = out_data_q;
	assign level     = count_q;

	always_comb begin
		push        = in_valid && in_ready;
		// Output stage refills as soon as it empties or is taken
		load        = (count_q != '0) && (!out_valid_q || out_ready);
		wr_ptr_d    = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
		rd_ptr_d    = load ? rd_ptr_q + 1'b1 : rd_ptr_q;
		count_d     = count_q + (AW+1)'(push) - (AW+1)'(load);
		out_valid_d = load ? 1'b1 : (out_ready ? 1'b0 : out_valid_q);
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wr_ptr_q    <= '0;
			rd_ptr_q    <= '0;
			count_q     <= '0;
			out_valid_q <= 1'b0;
		end else begin
			wr_ptr_q    <= wr_ptr_d;
			rd_ptr_q    <= rd_ptr_d;
			count_q     <= count_d;
			out_valid_q <= out_valid_d;
		end
	end

	// Storage carries no reset to stay a plain memory
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
		if (load) begin
			out_data_q <= mem_q[rd_ptr_q];
		end
	end

endmodule // cell_fifo

/* File: verification/cell_far_side.sv */
`timescale 1ns/1ps
module cell_far_side
	import cell_pkg::*;
(
	input  wire logic            core_clk,
	input  wire logic            reset,
	input  wire logic            restart,
	input  wire logic            hold,
	input  wire logic            slow,
	input  wire logic [16:0]     match_at,
	input  wire logic [7:0]      match_val,
	input  wire logic            src_ready,
	output cell_pkg::byte_beat_t src_beat,
	output logic                 dst_ready,
	output logic [16:0]          taken
);
	logic       offer_q;
	logic [7:0] byte_now;

	// Non-match bytes keep bit 7 set so they never equal a match byte
	assign byte_now = (taken == match_at) ? match_val : {1'b1, taken[6:0]};
	// Idle data is scrambled so a stale byte cannot pass for a good one
	assign src_beat = '{offer_q, offer_q ? byte_now : ~byte_now};

	always @(posedge core_clk or posedge reset) begin
		if (reset) begin
			offer_q   <= 1'b0;
			taken     <= '0;
			dst_ready <= 1'b0;
		end else begin
			if (restart) begin
				offer_q <= 1'b1;
				taken   <= '0;
			end else if (offer_q && src_ready) begin
				taken <= taken + 17'h1;
			end
			dst_ready <= hold ? 1'b0 : (slow ? 1'($urandom % 2) : 1'b1);
		end
	end
endmodule // cell_far_side

/* File: verification/cell_channel_tb.sv */
`timescale 1ns/1ps
module cell_channel_tb;
	import cell_pkg::*;
	logic             core_clk      = 1'b0;
	logic             reset         = 1'b1;
	reg_req_t         reg_req       = '0;
	logic [REG_W-1:0] rd_data;
	logic             trigger_event = 1'b0;
	byte_beat_t       src_beat;
	byte_beat_t       dst_beat;
	logic             src_ready;
	logic             dst_ready;
	logic             cell_done;
	logic             match_end;
	logic             restart       = 1'b0;
	logic             hold          = 1'b0;
	logic             slow          = 1'b0;
	logic [16:0]      match_at      = '0;
	logic [16:0]      taken;
	logic [7:0]       match_val     = '0;
	logic [15:0]      sz;
	logic [16:0]      at;
	logic             rd_last       = 1'b0;
	logic [31:0]      rd_q[$];
	logic [31:0]      dst_q[$];
	int               mismatches    = 0;
	int               checks_done   = 0;
	int               n_done        = 0;
	int               n_end         = 0;

	always #10 core_clk = ~core_clk;

	cell_channel #(.DEPTH(32)) dut (
		.core_clk     (core_clk),
		.reset        (reset),
		.reg_req      (reg_req),
		.rd_data      (rd_data),
		.trigger_event(trigger_event),
		.src_beat     (src_beat),
		.src_ready    (src_ready),
		.dst_beat     (dst_beat),
		.dst_ready    (dst_ready),
		.cell_done    (cell_done),
		.match_end    (match_end)
	);

	cell_far_side far (
		.core_clk (core_clk),
		.reset    (reset),
		.restart  (restart),
		.hold     (hold),
		.slow     (slow),
		.match_at (match_at),
		.match_val(match_val),
		.src_ready(src_ready),
		.src_beat (src_beat),
		.dst_ready(dst_ready),
		.taken    (taken)
	);

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Reads old values at the edge, so this sees what the last cycle held
	always @(posedge core_clk) begin
		if (dst_beat.valid === 1'b1 && dst_ready === 1'b1) begin
			if (dst_q.size() == 0)
				check("dst extra byte", 32'h1, 32'h0);
			else
				check("dst byte", {24'h0, dst_beat.data}, dst_q.pop_front());
		end
		if (rd_last)
			check("rd_data", rd_data, rd_q.pop_front());
		rd_last = reg_req.rd_en;
		if (cell_done === 1'b1)
			n_done++;
		if (match_end === 1'b1)
			n_end++;
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_req <= '{1'b1, 1'b0, a, d};
		@(posedge core_clk);
		reg_req.wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_req <= '{1'b0, 1'b1, a, 32'h0};
		rd_q.push_back(e);
		@(posedge core_clk);
		reg_req.rd_en <= 1'b0;
	endtask

	task automatic run_cell(input logic [1:0] mode, input logic [15:0] size, input logic [16:0] mat,
		input int bytes, input int done, input int ends, input logic stall);
		int         d0;
		int         e0;
		logic [7:0] mv;
		d0 = n_done;
		e0 = n_end;
		mv = 8'($urandom % 128);
		wr(OFS_CONTROL, {29'h0, mode, 1'b1});
		wr(OFS_CELL_SIZE, {16'h0, size});
		wr(OFS_MATCH, {24'h0, mv});
		@(posedge core_clk);
		match_val <= mv;
		match_at <= mat;
		restart <= 1'b1;
		hold <= stall;
		@(posedge core_clk);
		restart <= 1'b0;
		trigger_event <= 1'b1;
		for (int i = 0; i < bytes; i++)
			dst_q.push_back(32'((i == int'(mat)) ? mv : {1'b1, 7'(i)}));
		@(posedge core_clk);
		trigger_event <= 1'b0;
		if (stall) begin
			repeat (100) @(posedge core_clk);
			// Second event while armed must not restart the count
			trigger_event <= 1'b1;
			@(posedge core_clk);
			trigger_event <= 1'b0;
			check("buffer refuses", 32'(taken < 17'd40), 32'h1);
			rd(OFS_CELL_PROG, {15'h0, taken});
			hold <= 1'b0;
		end
		for (int w = 0; w < bytes * 4 + 300 && n_done == d0 && n_end == e0; w++)
			@(posedge core_clk);
		for (int w = 0; w < 300 && dst_q.size() != 0; w++)
			@(posedge core_clk);
		check("bytes left", 32'(dst_q.size()), 32'h0);
		check("bytes taken", {15'h0, taken}, 32'(bytes));
		check("cell done count", 32'(n_done - d0), 32'(done));
		check("match end count", 32'(n_end - e0), 32'(ends));
		rd(OFS_CELL_PROG, 32'h0);
	endtask

	initial begin
		void'($urandom(32'hc041));
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		rd(OFS_CELL_SIZE, 32'h0);
		rd(OFS_CELL_PROG, 32'h0);
		rd(OFS_MATCH, 32'h0);
		wr(OFS_CELL_SIZE, 32'hffff_abcd);
		rd(OFS_CELL_SIZE, 32'h0000_abcd);
		wr(OFS_MATCH, 32'hffff_ff5a);
		rd(OFS_MATCH, 32'h0000_005a);
		wr(OFS_CELL_PROG, 32'hffff_ffff);
		rd(OFS_CELL_PROG, 32'h0);
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, 32'h0);
		rd(OFS_CELL_SIZE, 32'h0000_abcd);
		slow <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			sz = 16'(2 + $urandom % 20);
			at = 17'($urandom % (sz - 16'h1));
			case (m)
				1: run_cell(2'(m), sz, at, int'(at) + 1 + int'(sz), 1, 0, 1'b0);
				2: run_cell(2'(m), sz, at, int'(at) + 1, 0, 1, 1'b0);
				default: run_cell(2'(m), sz, at, int'(sz), 1, 0, 1'b0);
			endcase
		end
		run_cell(2'd0, 16'd40, 17'd3, 40, 1, 0, 1'b1);
		// Match on the last byte of a cell ends the cell instead
		run_cell(2'd1, 16'd1, 17'd0, 1, 1, 0, 1'b0);
		slow <= 1'b0;
		run_cell(2'd0, 16'd0, 17'h1ffff, 65536, 1, 0, 1'b0);
		rd(OFS_CONTROL, 32'(1 << CTL_ENABLE_BIT));
		rd(OFS_STATUS, 32'((1 << STS_DONE_BIT) | (1 << STS_HIT_BIT)));
		wr(OFS_STATUS, 32'hffff_ffff);
		rd(OFS_STATUS, 32'h0);
		repeat (2) @(posedge core_clk);
		test_done;
	end

	// Longest case is the full-size cell at one byte per cycle
	initial begin
		repeat (95000) @(posedge core_clk);
		mismatches++;
		test_done;
	end
endmodule // cell_channel_tb
